// *** verilog/pioba_top.sv ***
// Parallel I/O port bank: 11 bidirectional and 2 input-only ports
//
// Contract
// - Eleven bidirectional, two input-only, per-line direction.
// - Single-line writes leave other lines untouched.
// - Per-line push-pull or open-drain output.
// - Per-line pull enable, edge shape, strength.
// - Input lines with no alternate function selected have their driver off.
// - Reset forces inputs, pulls off.
// - Alternate functions routable to selectable pins.
// - Unclaimed lines are software-controlled GPIO.
// - Bus/address port is 13 lines wide.
// - First converter port is 16 lines wide.
// - Second converter port is 8 lines wide.
`timescale 1ns/1ps
module pioba_top
  import pioba_pkg::*;
(
  input  wire logic              clk,            // 200 MHz system clock
  input  wire logic              reset_n,        // Async reset, active low
  input  wire logic [11:0]       s_axi_awaddr,   // Write address
  input  wire logic              s_axi_awvalid,  // Write address valid
  output logic                   s_axi_awready,  // Write address ready
  input  wire logic [31:0]       s_axi_wdata,    // Write data
  input  wire logic [3:0]        s_axi_wstrb,    // Byte strobes
  input  wire logic              s_axi_wvalid,   // Write data valid
  output logic                   s_axi_wready,   // Write data ready
  output logic [1:0]             s_axi_bresp,    // Write response
  output logic                   s_axi_bvalid,   // Write response valid
  input  wire logic              s_axi_bready,   // Write response ready
  input  wire logic [11:0]       s_axi_araddr,   // Read address
  input  wire logic              s_axi_arvalid,  // Read address valid
  output logic                   s_axi_arready,  // Read address ready
  output logic [31:0]            s_axi_rdata,    // Read data
  output logic [1:0]             s_axi_rresp,    // Read response
  output logic                   s_axi_rvalid,   // Read valid
  input  wire logic              s_axi_rready,   // Read ready
  input  wire logic [12:0][15:0] pin_in,         // Pin levels seen
  output logic      [12:0][15:0] pin_out,        // Pin drive value
  output logic      [12:0][15:0] pin_oe,         // Pin drive enable
  output logic      [12:0][15:0] pin_pull_en,    // Pull device enable
  output logic      [12:0][15:0] pin_shape,      // Edge shape select
  output logic      [12:0][15:0] pin_strength,   // Current strength select
  input  wire logic [2:0]        alt_fn_out,     // Peripheral output values
  input  wire logic [2:0]        alt_fn_oe,      // Peripheral drive requests
  output logic      [3:0]        alt_fn_in       // Routed peripheral inputs
);
`include "pioba_params.svh"
  localparam int NP = `PIOBA_NPORT;
  localparam int NA = `PIOBA_NALTIN;

  // ==================================================================
  // Reset release and shared helpers
  logic        rst_meta, rst_n;
  pioba_req_t  req;
  pioba_resp_t resp;
  pioba_pcfg_t cfg [NP];
  pioba_pcfg_t next_cfg [NP];
  logic [7:0]  asel [NA];
  logic [7:0]  next_asel [NA];
  logic [12:0][15:0] pin_sync;
  logic [12:0][15:0] next_pin_out, next_pin_oe;
  logic [3:0]  next_alt_fn_in;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Physical lines per port; the rest are tied off
  function automatic logic [4:0] port_width(input logic [3:0] p);
    case (p)
      4'h2:    port_width = 5'd13;
      4'h5:    port_width = 5'd16;
      4'h6:    port_width = 5'd4;
      4'h7:    port_width = 5'd5;
      4'h8:    port_width = 5'd7;
      4'ha:    port_width = 5'd16;
      4'hb:    port_width = 5'd6;
      4'hc:    port_width = 5'd8;
      default: port_width = 5'd8;
    endcase
  endfunction : port_width

  function automatic logic [15:0] line_mask(input logic [3:0] p);
    logic [16:0] t;
    t = (17'h1 << port_width(p)) - 17'h1;
    line_mask = t[15:0];
  endfunction : line_mask

  // Output-capable lines; input-only ports have none
  function automatic logic [15:0] out_mask(input logic [3:0] p);
    logic [12:0] io;
    io = ~`PIOBA_INONLY_MASK;
    out_mask = io[p] ? line_mask(p) : 16'h0000;
  endfunction : out_mask

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    merge = old;
  endfunction : merge

  function automatic logic [31:0] pair_mask(input logic [15:0] m);
    for (int l = 0; l < 16; l++) begin
      pair_mask[2*l +: 2] = {2{m[l]}};
    end
  endfunction : pair_mask

  // ==================================================================
  // Bus slave and pin synchroniser
  pioba_axil_slave u_slave (
    .clk           (clk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .req           (req),
    .resp          (resp)
  );

  pioba_sync #(.W(NP * 16)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_in),
    .q     (pin_sync)
  );

  // ==================================================================
  // Register writes
  logic [3:0] wp, rp;
  logic [2:0] wr_ofs, rd_ofs;
  logic       w_port, w_alt, r_port, r_alt;
  assign wp     = req.waddr[8:5];
  assign rp     = req.raddr[8:5];
  assign wr_ofs = req.waddr[4:2];
  assign rd_ofs = req.raddr[4:2];
  assign w_port = req.waddr < `PIOBA_PORT_END;
  assign r_port = req.raddr < `PIOBA_PORT_END;
  assign w_alt  = req.waddr >= `PIOBA_ALTIN_BASE && req.waddr < `PIOBA_ALTIN_END;
  assign r_alt  = req.raddr >= `PIOBA_ALTIN_BASE && req.raddr < `PIOBA_ALTIN_END;

  always_comb begin
    logic [31:0] m;
    logic [15:0] om, lm, s, c;
    m  = '0;
    om = out_mask(wp);
    lm = line_mask(wp);
    s  = '0;
    c  = '0;
    next_cfg  = cfg;
    next_asel = asel;
    if (req.wr && w_port) begin
      case (wr_ofs)
        `PIOBA_OFS_OUT: begin
          m = merge({16'h0000, cfg[wp].out}, req.wdata, req.wstrb);
          next_cfg[wp].out = m[15:0] & om;
        end
        `PIOBA_OFS_DIR: begin
          m = merge({16'h0000, cfg[wp].dir}, req.wdata, req.wstrb);
          next_cfg[wp].dir = m[15:0] & om;
        end
        `PIOBA_OFS_OD: begin
          m = merge({16'h0000, cfg[wp].od}, req.wdata, req.wstrb);
          next_cfg[wp].od = m[15:0] & om;
        end
        `PIOBA_OFS_PULL: begin
          m = merge({16'h0000, cfg[wp].pull}, req.wdata, req.wstrb);
          next_cfg[wp].pull = m[15:0] & lm;
        end
        `PIOBA_OFS_DRV: begin
          m = merge(cfg[wp].drv, req.wdata, req.wstrb);
          next_cfg[wp].drv = m & {om, om};
        end
        `PIOBA_OFS_ALTSEL: begin
          m = merge(cfg[wp].altsel, req.wdata, req.wstrb);
          next_cfg[wp].altsel = m & pair_mask(om);
        end
        `PIOBA_OFS_SETCLR: begin
          // Low half sets, high half clears, both toggles the line
          s = req.wstrb[0] ? {8'h00, req.wdata[7:0]} : 16'h0000;
          s[15:8] = req.wstrb[1] ? req.wdata[15:8] : 8'h00;
          c = req.wstrb[2] ? {8'h00, req.wdata[23:16]} : 16'h0000;
          c[15:8] = req.wstrb[3] ? req.wdata[31:24] : 8'h00;
          next_cfg[wp].out = ((cfg[wp].out & ~c) | (s & ~c)
                              | (~cfg[wp].out & s & c)) & om;
        end
        default: ;
      endcase
    end else if (req.wr && w_alt) begin
      next_asel[req.waddr[3:2]] = req.wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NP; p++) begin
        cfg[p].out    <= `PIOBA_RST_LINES;
        cfg[p].dir    <= `PIOBA_RST_LINES;
        cfg[p].od     <= `PIOBA_RST_LINES;
        cfg[p].pull   <= `PIOBA_RST_LINES;
        cfg[p].drv    <= `PIOBA_RST_WORD;
        cfg[p].altsel <= `PIOBA_RST_WORD;
      end
      for (int a = 0; a < NA; a++) begin
        asel[a] <= 8'h00;
      end
    end else begin
      cfg  <= next_cfg;
      asel <= next_asel;
    end
  end

  // ==================================================================
  // Register reads and decode errors
  always_comb begin
    resp       = '0;
    resp.werr  = !(w_port || w_alt) || (w_port && wr_ofs == `PIOBA_OFS_IN);
    resp.rerr  = !(r_port || r_alt);
    if (r_port) begin
      case (rd_ofs)
        `PIOBA_OFS_OUT:    resp.rdata = {16'h0000, cfg[rp].out};
        `PIOBA_OFS_DIR:    resp.rdata = {16'h0000, cfg[rp].dir};
        `PIOBA_OFS_OD:     resp.rdata = {16'h0000, cfg[rp].od};
        `PIOBA_OFS_PULL:   resp.rdata = {16'h0000, cfg[rp].pull};
        `PIOBA_OFS_DRV:    resp.rdata = cfg[rp].drv;
        `PIOBA_OFS_IN:     resp.rdata = {16'h0000, pin_sync[rp] & line_mask(rp)};
        `PIOBA_OFS_ALTSEL: resp.rdata = cfg[rp].altsel;
        default:           resp.rdata = {16'h0000, cfg[rp].out};
      endcase
    end else if (r_alt) begin
      resp.rdata = {24'h000000, asel[req.raddr[3:2]]};
    end
  end

  // ==================================================================
  // Pad drive: alternate function or software, then output style
  always_comb begin
    logic [1:0] sel;
    logic       val, en;
    sel = 2'h0;
    val = 1'b0;
    en  = 1'b0;
    for (int p = 0; p < NP; p++) begin
      for (int l = 0; l < 16; l++) begin
        sel = cfg[p].altsel[2*l +: 2];
        if (sel != 2'h0) begin
          val = alt_fn_out[sel - 2'h1];
          en  = alt_fn_oe[sel - 2'h1];
        end else begin
          val = cfg[p].out[l];
          en  = cfg[p].dir[l];
        end
        en = en & (|(out_mask(4'(p)) & (16'h0001 << l)));
        // Open-drain only ever pulls low
        next_pin_out[p][l] = cfg[p].od[l] ? 1'b0 : val & en;
        next_pin_oe[p][l]  = cfg[p].od[l] ? en & ~val : en;
      end
    end
    for (int a = 0; a < NA; a++) begin
      next_alt_fn_in[a] = pin_sync[asel[a][7:4]][asel[a][3:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out      <= '0;
      pin_oe       <= '0;
      pin_pull_en  <= '0;
      pin_shape    <= '0;
      pin_strength <= '0;
      alt_fn_in    <= '0;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      alt_fn_in <= next_alt_fn_in;
      for (int p = 0; p < NP; p++) begin
        pin_pull_en[p]  <= cfg[p].pull;
        pin_shape[p]    <= cfg[p].drv[15:0];
        pin_strength[p] <= cfg[p].drv[31:16];
      end
    end
  end

  // ==================================================================
  // Checks
  chk_reset_release: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (pin_oe == '0 && pin_pull_en == '0))
    else $error("pins not inputs without pulls after reset");

  chk_inonly_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    pin_oe[5] == 16'h0000 && pin_oe[12] == 16'h0000 && cfg[5].dir == 16'h0000)
    else $error("input-only port drives");

  chk_bus_width: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg[2].dir[12] && !cfg[2].od[12] && cfg[2].altsel[25:24] == 2'h0)
    |=> (pin_oe[2][12] && pin_oe[2][15:13] == 3'h0))
    else $error("bus port width wrong");

  chk_input_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg[0].dir[0] && cfg[0].altsel[1:0] == 2'h0) |=> !pin_oe[0][0])
    else $error("input line drives");

  chk_od_release: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg[0].od[1] && cfg[0].dir[1] && cfg[0].altsel[3:2] == 2'h0 && cfg[0].out[1])
    |=> (!pin_oe[0][1] && !pin_out[0][1]))
    else $error("open-drain drives high");

  chk_push_pull: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg[0].od[0] && cfg[0].dir[0] && cfg[0].altsel[1:0] == 2'h0)
    |=> (pin_oe[0][0] && pin_out[0][0] == $past(cfg[0].out[0])))
    else $error("push-pull line wrong");

  chk_set_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.waddr == 12'h01c && req.wdata == 32'h0001_0002 && req.wstrb == 4'hf)
    |=> ((cfg[0].out & 16'hfffc) == ($past(cfg[0].out) & 16'hfffc)
         && cfg[0].out[1:0] == 2'h2))
    else $error("single line set disturbed port");

  chk_alt_route: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg[3].altsel[1:0] == 2'h1 && !cfg[3].od[0] && alt_fn_oe[0])
    |=> (pin_oe[3][0] && pin_out[3][0] == $past(alt_fn_out[0])))
    else $error("alternate output not routed");

  chk_pull_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pin_pull_en[1] == $past(cfg[1].pull))
    else $error("pull enable not applied");
endmodule : pioba_top

// *** common/pioba_params.svh ***
// Constants for the parallel I/O port bank: map, widths, reset values
`ifndef PIOBA_PARAMS_SVH
`define PIOBA_PARAMS_SVH
// ==================================================================
// Geometry
`define PIOBA_NPORT        13
`define PIOBA_LW           16
`define PIOBA_NALT         3
`define PIOBA_NALTIN       4
`define PIOBA_INONLY_MASK  13'h1020
`define PIOBA_AW           12
// ==================================================================
// Register map, port p at base p * stride
`define PIOBA_PORT_STRIDE  12'h020
`define PIOBA_PORT_END     12'h1a0
`define PIOBA_OFS_OUT      3'h0
`define PIOBA_OFS_DIR      3'h1
`define PIOBA_OFS_OD       3'h2
`define PIOBA_OFS_PULL     3'h3
`define PIOBA_OFS_DRV      3'h4
`define PIOBA_OFS_IN       3'h5
`define PIOBA_OFS_ALTSEL   3'h6
`define PIOBA_OFS_SETCLR   3'h7
`define PIOBA_ALTIN_BASE   12'h200
`define PIOBA_ALTIN_END    12'h210
// ==================================================================
// Reset values and responses
`define PIOBA_RST_LINES    16'h0000
`define PIOBA_RST_WORD     32'h0000_0000
`define PIOBA_RESP_OKAY    2'h0
`define PIOBA_RESP_SLVERR  2'h2
`endif

// *** common/pioba_pkg.sv ***
// Types shared by the parallel I/O port bank
package pioba_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] waddr;
    logic [11:0] raddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } pioba_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        rerr;
    logic        werr;
  } pioba_resp_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] dir;
    logic [15:0] od;
    logic [15:0] pull;
    logic [31:0] drv;
    logic [31:0] altsel;
  } pioba_pcfg_t;
endpackage : pioba_pkg

// *** verilog/pioba_sync.sv ***
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module pioba_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,     // System clock
  input  wire logic         rst_n,   // Synchronised reset
  input  wire logic [W-1:0] d,       // Asynchronous levels
  output logic      [W-1:0] q        // Synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pioba_sync

// *** verilog/pioba_axil_slave.sv ***
// AXI4-Lite slave front end for the port bank registers
`timescale 1ns/1ps
module pioba_axil_slave
  import pioba_pkg::*;
(
  input  wire logic        clk,            // System clock
  input  wire logic        rst_n,          // Synchronised reset
  input  wire logic [11:0] s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Byte strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [11:0] s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read valid
  input  wire logic        s_axi_rready,   // Read ready
  output pioba_req_t       req,            // Access to register core
  input  wire pioba_resp_t resp            // Core decode answer
);
`include "pioba_params.svh"
  logic        aw_full, next_aw_full, w_full, next_w_full;
  logic [11:0] awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0]  wstrb, next_wstrb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // Response must be taken before the next address is accepted
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    req       = '0;
    req.wr    = aw_full && w_full && !s_axi_bvalid;
    req.waddr = awaddr;
    req.wdata = wdata;
    req.wstrb = wstrb;
    req.rd    = s_axi_arvalid && s_axi_arready;
    req.raddr = s_axi_araddr;
  end

  always_comb begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_awaddr  = awaddr;
    next_wdata   = wdata;
    next_wstrb   = wstrb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_wdata  = s_axi_wdata;
      next_wstrb  = s_axi_wstrb;
    end
    if (req.wr) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = resp.werr ? `PIOBA_RESP_SLVERR : `PIOBA_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (req.rd) begin
      next_rvalid = 1'b1;
      next_rdata  = resp.rdata;
      next_rresp  = resp.rerr ? `PIOBA_RESP_SLVERR : `PIOBA_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      awaddr       <= '0;
      wdata        <= '0;
      wstrb        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PIOBA_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `PIOBA_RESP_OKAY;
      s_axi_rdata  <= '0;
    end else begin
      aw_full      <= next_aw_full;
      w_full       <= next_w_full;
      awaddr       <= next_awaddr;
      wdata        <= next_wdata;
      wstrb        <= next_wstrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end
endmodule : pioba_axil_slave

// *** dv/pioba_pins.sv ***
// Board-side model of the pins: outside drivers, pull devices and floating lines
`timescale 1ns/1ps
module pioba_pins #(
  parameter logic PULL_LVL = 1'b1
) (
  input  wire logic              clk,          // System clock
  input  wire logic [12:0][15:0] pin_out,      // Device drive value
  input  wire logic [12:0][15:0] pin_oe,       // Device drive enable
  input  wire logic [12:0][15:0] pin_pull_en,  // Pull device enable
  input  wire logic [12:0][15:0] ext_en,       // Board drives the line
  input  wire logic [12:0][15:0] ext_val,      // Board drive value
  output logic      [12:0][15:0] pin_in        // Resolved pin levels
);
  // ==================================================================
  // Wire resolution
  logic [12:0][15:0] last = '0;
  // Floating lines flip each cycle, so a stale level never passes for a driven one
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & pin_pull_en & {208{PULL_LVL}})
    | (~pin_oe & ~ext_en & ~pin_pull_en & ~last);
  always_ff @(posedge clk) last <= pin_in;
endmodule : pioba_pins

// *** dv/parallel_io_port_bank_test.sv ***
// Self-checking testbench for the parallel I/O port bank
`timescale 1ns/1ps
`include "pioba_params.svh"
module parallel_io_port_bank_test;
  // ==================================================================
  // Stimulus and observed signals
  localparam logic [1:0] OK = `PIOBA_RESP_OKAY;
  localparam logic [1:0] ER = `PIOBA_RESP_SLVERR;
  logic clk = 1'b0, reset_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [12:0][15:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_shape, pin_strength;
  logic [12:0][15:0] ext_en = '0, ext_val = '0;
  logic [2:0] alt_fn_out = '0, alt_fn_oe = '0;
  logic [3:0] alt_fn_in;
  int mismatches = 0, checks_done = 0, cycles = 0;

  always #2.5 clk = ~clk;

  pioba_top pioba_top_inst (.clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
    .pin_shape(pin_shape), .pin_strength(pin_strength),
    .alt_fn_out(alt_fn_out), .alt_fn_oe(alt_fn_oe), .alt_fn_in(alt_fn_in));

  pioba_pins pioba_pins_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_en(pin_pull_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // ==================================================================
  // Comparison and bus tasks
  task automatic flag(input logic ok, input string what);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : flag
  task automatic cmp_lines(input logic [15:0] got, input logic [15:0] exp, input string w);
    flag(got === exp, w);
  endtask : cmp_lines
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string w);
    flag(got === exp, w);
  endtask : cmp_word
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    flag(got === exp, "bus response");
  endtask : cmp_resp

  function automatic logic [11:0] ra(input int p, input logic [2:0] o);
    return `PIOBA_PORT_STRIDE * 12'(p) + {7'h00, o, 2'h0};
  endfunction : ra

  // Handshakes are judged at the falling edge, released after the rising one
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    b_t = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    cmp_resp(r, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    r_t = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    cmp_word(d, ed, "read data");
    cmp_resp(r, er);
  endtask : axi_rd

  // Covers register edge, pin register and the two-flop input path
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle

  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==================================================================
  // Test sequence
  initial begin
    ext_en[5] = 16'hffff;
    ext_val[5] = 16'hffff;
    ext_en[12] = 16'hffff;
    ext_val[12] = 16'hffff;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_lines({15'h0, |{pin_oe, pin_pull_en}}, 16'h0, "idle after reset");
    axi_wr(ra(0, `PIOBA_OFS_OUT), 32'h0000_00a5, OK);
    axi_wr(ra(0, `PIOBA_OFS_DIR), 32'h0000_ffff, OK);
    settle;
    cmp_lines(pin_oe[0], 16'h00ff, "port 0 enable");
    cmp_lines(pin_out[0], 16'h00a5, "port 0 drive");
    axi_rd(ra(0, `PIOBA_OFS_IN), 32'h0000_00a5, OK);
    axi_wr(ra(0, `PIOBA_OFS_SETCLR), 32'h0001_0002, OK);
    axi_rd(ra(0, `PIOBA_OFS_OUT), 32'h0000_00a6, OK);
    axi_wr(ra(0, `PIOBA_OFS_OD), 32'h0000_0003, OK);
    settle;
    cmp_lines(pin_oe[0], 16'h00fd, "open-drain enable");
    cmp_lines(pin_out[0], 16'h00a4, "open-drain drive");
    axi_wr(ra(0, `PIOBA_OFS_DIR), 32'h0, OK);
    axi_wr(ra(2, `PIOBA_OFS_DIR), 32'h0000_ffff, OK);
    axi_wr(ra(5, `PIOBA_OFS_DIR), 32'h0000_ffff, OK);
    axi_wr(ra(12, `PIOBA_OFS_DIR), 32'h0000_ffff, OK);
    settle;
    cmp_lines(pin_oe[0], 16'h0, "input released");
    cmp_lines(pin_oe[2], 16'h1fff, "13-line port");
    cmp_lines(pin_oe[5] | pin_oe[12], 16'h0, "input-only enable");
    axi_rd(ra(5, `PIOBA_OFS_IN), 32'h0000_ffff, OK);
    axi_rd(ra(12, `PIOBA_OFS_IN), 32'h0000_00ff, OK);
    axi_wr(ra(1, `PIOBA_OFS_PULL), 32'h0000_00f0, OK);
    axi_wr(ra(1, `PIOBA_OFS_DRV), 32'h0003_000c, OK);
    alt_fn_out <= 3'h1;
    alt_fn_oe <= 3'h1;
    axi_wr(ra(3, `PIOBA_OFS_ALTSEL), 32'h0000_0001, OK);
    axi_wr(ra(4, `PIOBA_OFS_ALTSEL), 32'h0000_0010, OK);
    axi_wr(`PIOBA_ALTIN_BASE, 32'h0000_0030, OK);
    settle;
    cmp_lines(pin_pull_en[1], 16'h00f0, "pull enable");
    cmp_lines(pin_shape[1], 16'h000c, "edge shape");
    cmp_lines(pin_strength[1], 16'h0003, "strength");
    cmp_lines(pin_oe[3] & pin_out[3], 16'h0001, "alt on port 3");
    cmp_lines(pin_oe[4] & pin_out[4], 16'h0004, "alt on port 4");
    cmp_lines({15'h0, alt_fn_in[0]}, 16'h0001, "alt input route");
    axi_rd(12'h300, 32'h0, ER);
    axi_wr(ra(0, `PIOBA_OFS_IN), 32'h1, ER);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_lines({15'h0, |{pin_oe, pin_pull_en}}, 16'h0, "idle in reset");
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    axi_rd(ra(2, `PIOBA_OFS_DIR), 32'h0, OK);
    report_and_stop();
  end
endmodule : parallel_io_port_bank_test
